//--- rtl/dma_transfer_mailbox.sv
/*
 * DMA transfer mailbox: transmit and receive byte FIFOs between the DSP core and an
 * external DMA controller, with bulk counters, busy flags and DSP interrupt pulses.
 * Assumes all pins are synchronous to ref_clk_in and each strobe lasts at least one cycle.
 */
// Summary of operation
// - Separate strobes: read or write with acknowledge low.
// - Shared strobe: direction line selects read or write.
// - Fly-by inverts command sense for the mailbox.
// - Edge mode: request edge per transfer.
// - Two 18-byte FIFOs, nine DSP words each.
// - Five-bit bulk size and remaining counter per direction.
// - Transmit bulk write loads count, busy, request.
// - Transmit count decrements per DMA write.
// - Acknowledge high pauses; request stays, count holds.
// - Transmit count zero clears request, then busy once the buffer drains.
// - Transmit busy fall unmasked pulses interrupt one.
// - Transmit bytes fill low byte then high byte.
// - Receive bulk write loads count, busy, request.
// - Receive count decrements per DMA read.
// - Receive count zero clears busy and request.
// - Receive busy fall unmasked pulses interrupt two.
// - DMA reads return bytes low then high.
// - DMA behaviour only when DMA mode set.
`timescale 1ns/1ns
`default_nettype none
module dma_transfer_mailbox
	import dma_mailbox_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic dma_mode_in,
	input wire bus_mode_e bus_mode_in,
	input wire logic flyby_in,
	input wire logic edge_request_mode_in,
	input wire dma_pins_s dma_pins_in,
	input wire logic [7:0] dma_data_in,
	output logic [7:0] dma_data_out,
	output logic dma_data_oe_n_out,
	output logic tx_dma_request_out,
	output logic rx_dma_request_out,
	output logic tx_accept_ready_out,
	input wire logic dsp_wr_in,
	input wire logic dsp_rd_in,
	input wire logic [ADDR_W-1:0] dsp_addr_in,
	input wire logic [15:0] dsp_wdata_in,
	output logic [15:0] dsp_rdata_out,
	input wire logic tx_irq_mask_in,
	input wire logic rx_irq_mask_in,
	output logic tx_busy_flag_out,
	output logic rx_busy_flag_out,
	output logic dsp_irq_line_1_out,
	output logic dsp_irq_line_2_out
);
	logic [7:0] tx_mem_q [FIFO_BYTES];
	logic [7:0] rx_mem_q [FIFO_BYTES];
	logic [CNT_W-1:0] tx_bulk_size_q, rx_bulk_size_q;
	logic [CNT_W-1:0] tx_remaining_count_q, rx_remaining_count_q;
	logic tx_busy_flag_q, rx_busy_flag_q;
	logic store_prev_q, drive_prev_q, tx_gap_q, rx_gap_q;
	tx_entry_s buf_q [2];
	logic [1:0] buf_cnt_q;
	logic rd_cond, wr_cond, store_cond, drive_cond, store_ev, drive_ev;
	logic tx_push, tx_pop, buf_in_ready, buf_out_ready, buf_out_valid, rx_take;
	logic tx_bulk_wr, rx_bulk_wr, tx_busy_d, rx_busy_d;
	logic [CNT_W-1:0] tx_idx, rx_idx, rx_word, dsp_tx_word;
	logic [7:0] rx_byte_sel;
	logic dsp_tx_hit, dsp_rx_hit;

	always_comb begin
		if (bus_mode_in == BUS_SEPARATE) begin
			rd_cond = !dma_pins_in.ack_n && !dma_pins_in.rd_n;
			wr_cond = !dma_pins_in.ack_n && !dma_pins_in.wr_n;
		end else begin
			rd_cond = !dma_pins_in.ack_n && !dma_pins_in.data_strobe_n && dma_pins_in.rw;
			wr_cond = !dma_pins_in.ack_n && !dma_pins_in.data_strobe_n && !dma_pins_in.rw;
		end
	end

	// The mailbox stores on a read command and drives on a write command in fly-by.
	assign store_cond = dma_mode_in && (flyby_in ? rd_cond : wr_cond);
	assign drive_cond = dma_mode_in && (flyby_in ? wr_cond : rd_cond);
	// One transaction per strobe assertion, so a long strobe counts once.
	assign store_ev = store_cond && !store_prev_q;
	assign drive_ev = drive_cond && !drive_prev_q;

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			store_prev_q <= 1'b0;
			drive_prev_q <= 1'b0;
		end else begin
			store_prev_q <= store_cond;
			drive_prev_q <= drive_cond;
		end
	end

	// Transmit path: a write refused by a full buffer is not counted.
	assign tx_idx = tx_bulk_size_q - tx_remaining_count_q;
	assign tx_push = store_ev && (tx_remaining_count_q != CNT_ZERO) && buf_in_ready;
	assign buf_in_ready = (buf_cnt_q != BUF_FULL);
	assign buf_out_valid = (buf_cnt_q != BUF_EMPTY);
	assign dsp_tx_word = dsp_addr_in - ADDR_TX_BASE;
	assign dsp_tx_hit = dsp_addr_in < (ADDR_TX_BASE + CNT_W'(FIFO_WORDS));
	// A DSP write to the transmit words takes the array port, so the buffer waits.
	assign buf_out_ready = !(dsp_wr_in && (dsp_tx_hit || dsp_addr_in == ADDR_TX_LO
		|| dsp_addr_in == ADDR_TX_HI));
	assign tx_pop = buf_out_valid && buf_out_ready;

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			buf_cnt_q <= BUF_EMPTY;
			buf_q[0] <= '0;
			buf_q[1] <= '0;
		end else begin
			if (tx_pop) begin
				buf_q[0] <= buf_q[1];
			end
			if (tx_push) begin
				if (buf_cnt_q == BUF_EMPTY || (buf_cnt_q == BUF_ONE && tx_pop)) begin
					buf_q[0] <= '{data: dma_data_in, idx: tx_idx};
				end else begin
					buf_q[1] <= '{data: dma_data_in, idx: tx_idx};
				end
			end
			buf_cnt_q <= buf_cnt_q + {1'b0, tx_push} - {1'b0, tx_pop};
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (tx_pop) begin
			tx_mem_q[buf_q[0].idx] <= buf_q[0].data;
		end else if (dsp_wr_in && dsp_tx_hit) begin
			tx_mem_q[{dsp_tx_word[3:0], 1'b0}] <= dsp_wdata_in[7:0];
			tx_mem_q[{dsp_tx_word[3:0], 1'b1}] <= dsp_wdata_in[15:8];
		end else if (dsp_wr_in && dsp_addr_in == ADDR_TX_LO) begin
			tx_mem_q[{ALIAS_WORD, 1'b0}] <= dsp_wdata_in[7:0];
		end else if (dsp_wr_in && dsp_addr_in == ADDR_TX_HI) begin
			tx_mem_q[{ALIAS_WORD, 1'b1}] <= dsp_wdata_in[7:0];
		end
	end

	// Receive path.
	assign rx_idx = rx_bulk_size_q - rx_remaining_count_q;
	assign rx_take = drive_ev && (rx_remaining_count_q != CNT_ZERO);
	assign rx_byte_sel = rx_mem_q[rx_idx];
	assign rx_word = dsp_addr_in - ADDR_RX_BASE;
	assign dsp_rx_hit = dsp_addr_in >= ADDR_RX_BASE
		&& dsp_addr_in < (ADDR_RX_BASE + CNT_W'(FIFO_WORDS));

	always_ff @(posedge ref_clk_in) begin
		if (dsp_wr_in && dsp_rx_hit) begin
			rx_mem_q[{rx_word[3:0], 1'b0}] <= dsp_wdata_in[7:0];
			rx_mem_q[{rx_word[3:0], 1'b1}] <= dsp_wdata_in[15:8];
		end else if (dsp_wr_in && dsp_addr_in == ADDR_RX_LO) begin
			rx_mem_q[{ALIAS_WORD, 1'b0}] <= dsp_wdata_in[7:0];
		end else if (dsp_wr_in && dsp_addr_in == ADDR_RX_HI) begin
			rx_mem_q[{ALIAS_WORD, 1'b1}] <= dsp_wdata_in[7:0];
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			dma_data_out <= 8'h00;
			dma_data_oe_n_out <= 1'b1;
		end else begin
			if (rx_take) begin
				dma_data_out <= rx_byte_sel;
			end
			dma_data_oe_n_out <= !drive_cond;
		end
	end

	// Bulk control per direction.
	assign tx_bulk_wr = dsp_wr_in && dsp_addr_in == ADDR_TX_BULK;
	assign rx_bulk_wr = dsp_wr_in && dsp_addr_in == ADDR_RX_BULK;
	// Busy stays up until the last buffered byte has landed in the array.
	assign tx_busy_d = tx_bulk_wr || (tx_busy_flag_q
		&& !(tx_remaining_count_q == CNT_ZERO && !buf_out_valid));
	assign rx_busy_d = rx_bulk_wr || (rx_busy_flag_q
		&& rx_remaining_count_q != CNT_ZERO);

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			tx_bulk_size_q <= CNT_ZERO;
			tx_remaining_count_q <= CNT_ZERO;
			tx_busy_flag_q <= 1'b0;
		end else begin
			tx_busy_flag_q <= tx_busy_d;
			if (tx_bulk_wr) begin
				tx_bulk_size_q <= dsp_wdata_in[CNT_W-1:0];
				tx_remaining_count_q <= dsp_wdata_in[CNT_W-1:0];
			end else if (tx_push) begin
				tx_remaining_count_q <= tx_remaining_count_q - CNT_ONE;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			rx_bulk_size_q <= CNT_ZERO;
			rx_remaining_count_q <= CNT_ZERO;
			rx_busy_flag_q <= 1'b0;
		end else begin
			rx_busy_flag_q <= rx_busy_d;
			if (rx_bulk_wr) begin
				rx_bulk_size_q <= dsp_wdata_in[CNT_W-1:0];
				rx_remaining_count_q <= dsp_wdata_in[CNT_W-1:0];
			end else if (rx_take) begin
				rx_remaining_count_q <= rx_remaining_count_q - CNT_ONE;
			end
		end
	end

	// Request pins; edge mode opens a two-cycle gap after each transfer.
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			tx_gap_q <= 1'b0;
			rx_gap_q <= 1'b0;
			tx_dma_request_out <= 1'b0;
			rx_dma_request_out <= 1'b0;
			tx_accept_ready_out <= 1'b1;
		end else begin
			tx_gap_q <= edge_request_mode_in && tx_push;
			rx_gap_q <= edge_request_mode_in && rx_take;
			tx_dma_request_out <= dma_mode_in && tx_busy_d && !tx_bulk_wr
				? (tx_remaining_count_q != CNT_ZERO && !(edge_request_mode_in
				&& (tx_push || tx_gap_q || !buf_in_ready)))
				: (dma_mode_in && tx_bulk_wr);
			rx_dma_request_out <= dma_mode_in && rx_busy_d && !rx_bulk_wr
				? (rx_remaining_count_q != CNT_ZERO && !(edge_request_mode_in
				&& (rx_take || rx_gap_q)))
				: (dma_mode_in && rx_bulk_wr);
			tx_accept_ready_out <= (buf_cnt_q + {1'b0, tx_push} - {1'b0, tx_pop}) != BUF_FULL;
		end
	end

	// Flags, interrupt pulses and DSP read data.
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			tx_busy_flag_out <= 1'b0;
			rx_busy_flag_out <= 1'b0;
			dsp_irq_line_1_out <= 1'b0;
			dsp_irq_line_2_out <= 1'b0;
		end else begin
			tx_busy_flag_out <= tx_busy_d;
			rx_busy_flag_out <= rx_busy_d;
			dsp_irq_line_1_out <= tx_busy_flag_q && !tx_busy_d && !tx_irq_mask_in;
			dsp_irq_line_2_out <= rx_busy_flag_q && !rx_busy_d && !rx_irq_mask_in;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			dsp_rdata_out <= 16'h0000;
		end else if (dsp_rd_in) begin
			if (dsp_tx_hit) begin
				dsp_rdata_out <= {tx_mem_q[{dsp_tx_word[3:0], 1'b1}],
					tx_mem_q[{dsp_tx_word[3:0], 1'b0}]};
			end else if (dsp_addr_in == ADDR_TX_LO) begin
				dsp_rdata_out <= {8'h00, tx_mem_q[{ALIAS_WORD, 1'b0}]};
			end else if (dsp_addr_in == ADDR_TX_HI) begin
				dsp_rdata_out <= {8'h00, tx_mem_q[{ALIAS_WORD, 1'b1}]};
			end else if (dsp_rx_hit) begin
				dsp_rdata_out <= {rx_mem_q[{rx_word[3:0], 1'b1}], rx_mem_q[{rx_word[3:0], 1'b0}]};
			end else if (dsp_addr_in == ADDR_RX_LO) begin
				dsp_rdata_out <= {8'h00, rx_mem_q[{ALIAS_WORD, 1'b0}]};
			end else if (dsp_addr_in == ADDR_RX_HI) begin
				dsp_rdata_out <= {8'h00, rx_mem_q[{ALIAS_WORD, 1'b1}]};
			end else if (dsp_addr_in == ADDR_TX_BULK) begin
				dsp_rdata_out <= {11'h000, tx_bulk_size_q};
			end else if (dsp_addr_in == ADDR_RX_BULK) begin
				dsp_rdata_out <= {11'h000, rx_bulk_size_q};
			end else if (dsp_addr_in == ADDR_STATUS) begin
				dsp_rdata_out <= {14'h0000, rx_busy_flag_q, tx_busy_flag_q};
			end else begin
				dsp_rdata_out <= 16'h0000;
			end
		end
	end

	property p_tx_load;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		tx_bulk_wr |=> tx_busy_flag_q && tx_remaining_count_q == $past(dsp_wdata_in[CNT_W-1:0]);
	endproperty
	a_tx_load: assert property (p_tx_load) else $error("tx bulk write did not load");
	property p_tx_dec;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		tx_push && !tx_bulk_wr |=> tx_remaining_count_q == $past(tx_remaining_count_q) - CNT_ONE;
	endproperty
	a_tx_dec: assert property (p_tx_dec) else $error("tx count did not decrement");
	property p_pause;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		dma_pins_in.ack_n && !edge_request_mode_in && tx_dma_request_out && !tx_bulk_wr
			|=> tx_dma_request_out && $stable(tx_remaining_count_q);
	endproperty
	a_pause: assert property (p_pause) else $error("pause dropped request or counted");
	property p_tx_done;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		$fell(tx_busy_flag_out) |-> tx_remaining_count_q == CNT_ZERO && !tx_dma_request_out;
	endproperty
	a_tx_done: assert property (p_tx_done) else $error("tx busy fell early");
	property p_tx_irq;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		$fell(tx_busy_flag_out) && !$past(tx_irq_mask_in) |-> dsp_irq_line_1_out;
	endproperty
	a_tx_irq: assert property (p_tx_irq) else $error("tx interrupt missing");
	property p_rx_dec;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		rx_take && !rx_bulk_wr |=> rx_remaining_count_q == $past(rx_remaining_count_q) - CNT_ONE;
	endproperty
	a_rx_dec: assert property (p_rx_dec) else $error("rx count did not decrement");
	property p_rx_order;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		rx_take |=> dma_data_out == $past(rx_byte_sel);
	endproperty
	a_rx_order: assert property (p_rx_order) else $error("rx byte out of order");
	property p_rx_irq;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		$fell(rx_busy_flag_out) && !$past(rx_irq_mask_in)
			|-> dsp_irq_line_2_out && !rx_dma_request_out;
	endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("rx completion wrong");
	property p_edge;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		edge_request_mode_in && rx_take && !rx_bulk_wr |=> !rx_dma_request_out;
	endproperty
	a_edge: assert property (p_edge) else $error("no request edge per transfer");
	property p_reset;
		@(posedge ref_clk_in)
		!resetn_in |=> !tx_dma_request_out && !rx_dma_request_out && !tx_busy_flag_out;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule : dma_transfer_mailbox
`default_nettype wire

//--- rtl/dma_mailbox_pkg.sv
/*
 * Constants and carrier types shared by the DMA transfer mailbox.
 * Assumes a DSP register port of 5 address bits and 16 data bits and an 8-bit DMA data bus.
 */
`default_nettype none
package dma_mailbox_pkg;
	localparam int FIFO_BYTES = 18;
	localparam int FIFO_WORDS = 9;
	localparam int CNT_W = 5;
	localparam int ADDR_W = 5;
	localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
	localparam logic [3:0] ALIAS_WORD = 4'h8;
	// DSP address map.
	localparam logic [ADDR_W-1:0] ADDR_TX_BASE = 5'h00;
	localparam logic [ADDR_W-1:0] ADDR_TX_LO = 5'h09;
	localparam logic [ADDR_W-1:0] ADDR_TX_HI = 5'h0A;
	localparam logic [ADDR_W-1:0] ADDR_RX_BASE = 5'h10;
	localparam logic [ADDR_W-1:0] ADDR_RX_LO = 5'h19;
	localparam logic [ADDR_W-1:0] ADDR_RX_HI = 5'h1A;
	localparam logic [ADDR_W-1:0] ADDR_TX_BULK = 5'h1B;
	localparam logic [ADDR_W-1:0] ADDR_RX_BULK = 5'h1C;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h1D;
	localparam logic [1:0] BUF_EMPTY = 2'h0;
	localparam logic [1:0] BUF_ONE = 2'h1;
	localparam logic [1:0] BUF_FULL = 2'h2;
	typedef enum logic {
		BUS_SEPARATE = 1'b0,
		BUS_SHARED = 1'b1
	} bus_mode_e;
	typedef struct packed {
		logic ack_n;
		logic rd_n;
		logic wr_n;
		logic rw;
		logic data_strobe_n;
	} dma_pins_s;
	typedef struct packed {
		logic [7:0] data;
		logic [CNT_W-1:0] idx;
	} tx_entry_s;
endpackage : dma_mailbox_pkg
`default_nettype wire

//--- tb/dma_host_model.sv
/*
 * Behavioural external DMA controller that strobes the mailbox one byte at a time.
 * Assumes the bench holds cmd_in until done_out and then clears it.
 */
`timescale 1ns/1ns
`default_nettype none
module dma_host_model
	import dma_mailbox_pkg::*;
(
	input wire logic clk_in,
	input wire bus_mode_e bus_mode_in,
	input wire logic flyby_in,
	input wire logic hold_off_in,
	input wire logic edge_in,
	input wire logic [1:0] req_in,
	input wire logic [1:0] cmd_in,
	input wire logic [7:0] byte_in,
	output dma_pins_s pins_out,
	output logic [7:0] data_out,
	output logic done_out
);
	int rise[2];
	int used[2];
	int d;
	int w;
	logic [1:0] req_d;
	logic rd_cmd;
	logic rd_n_q;
	logic wr_n_q;
	logic rw_q;
	logic ds_n_q;
	// An edge-sensitive controller remembers every request edge, even one seen early.
	always @(posedge clk_in) begin
		for (int i = 0; i < 2; i++) begin
			if (req_in[i] && !req_d[i]) begin
				rise[i] <= rise[i] + 1;
			end
		end
		req_d <= req_in;
	end
	assign pins_out = {hold_off_in, rd_n_q, wr_n_q, rw_q, ds_n_q};
	initial begin
		{rd_n_q, wr_n_q, rw_q, ds_n_q} = 4'hF;
		data_out = 8'h00;
		done_out = 1'b0;
		forever begin
			@(posedge clk_in);
			if (!edge_in) begin
				used = rise;
			end
			if (cmd_in != 2'h0) begin
				d = int'(cmd_in) - 1;
				w = 0;
				while (edge_in && used[d] == rise[d] && w < 60) begin
					@(posedge clk_in);
					w++;
				end
				used[d]++;
				rd_cmd = (cmd_in == 2'h2) ^ flyby_in;
				if (bus_mode_in == BUS_SHARED) begin
					rw_q <= rd_cmd;
					ds_n_q <= 1'b0;
				end else begin
					rd_n_q <= !rd_cmd;
					wr_n_q <= rd_cmd;
				end
				data_out <= (cmd_in == 2'h1) ? byte_in : ~data_out;
				@(posedge clk_in);
				{rd_n_q, wr_n_q, ds_n_q} <= 3'h7;
				data_out <= ~data_out;
				done_out <= 1'b1;
				@(posedge clk_in);
				done_out <= 1'b0;
			end
		end
	end
endmodule : dma_host_model
`default_nettype wire

//--- tb/tb.sv
/*
 * Self-checking bench for the DMA transfer mailbox across all bus variants.
 * Assumes the host model stands on the DMA pins and the bench plays the DSP.
 */
`timescale 1ns/1ns
`default_nettype none
module tb;
	import dma_mailbox_pkg::*;
	logic clk, rstn, dma_mode, flyby, edge_m, hold, dsp_wr, dsp_rd, txm, rxm;
	bus_mode_e bmode;
	logic [1:0] cmd;
	logic [7:0] byt, ddin, dout, hi, b;
	logic [4:0] dsp_addr;
	logic [15:0] dsp_wdata, rdata, r;
	logic [15:0] rq[9];
	logic oe_n, txr, rxr, rdy, txb, rxb, irq1, irq2, done, txd, rxd;
	dma_pins_s pins;
	int mismatches, check_count, cyc, n1, n2, tr, rr, n, k, w, e1, r0, ol, o0;
	int seed = 32'haaa8d572;
	logic [7:0] q[$];
	dma_transfer_mailbox u_dma_transfer_mailbox (.ref_clk_in(clk), .resetn_in(rstn),
		.dma_mode_in(dma_mode), .bus_mode_in(bmode), .flyby_in(flyby),
		.edge_request_mode_in(edge_m), .dma_pins_in(pins), .dma_data_in(ddin),
		.dma_data_out(dout), .dma_data_oe_n_out(oe_n), .tx_dma_request_out(txr),
		.rx_dma_request_out(rxr), .tx_accept_ready_out(rdy), .dsp_wr_in(dsp_wr),
		.dsp_rd_in(dsp_rd), .dsp_addr_in(dsp_addr), .dsp_wdata_in(dsp_wdata),
		.dsp_rdata_out(rdata), .tx_irq_mask_in(txm), .rx_irq_mask_in(rxm),
		.tx_busy_flag_out(txb), .rx_busy_flag_out(rxb), .dsp_irq_line_1_out(irq1),
		.dsp_irq_line_2_out(irq2));
	dma_host_model u_dma_host_model (.clk_in(clk), .bus_mode_in(bmode), .flyby_in(flyby),
		.hold_off_in(hold), .edge_in(edge_m), .req_in({rxr, txr}), .cmd_in(cmd),
		.byte_in(byt), .pins_out(pins), .data_out(ddin), .done_out(done));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic dsp(input logic wr, input logic [4:0] a, input logic [15:0] d);
		dsp_wr <= wr;
		dsp_rd <= !wr;
		dsp_addr <= a;
		dsp_wdata <= d;
		@(posedge clk);
		dsp_wr <= 1'b0;
		dsp_rd <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		r = rdata;
		@(posedge clk);
	endtask : dsp
	task automatic dma(input logic [1:0] c, input logic [7:0] v);
		cmd <= c;
		byt <= v;
		w = 0;
		do begin
			@(posedge clk);
			w++;
		end while (done !== 1'b1 && w < 100);
		cmd <= 2'h0;
		@(posedge clk);
	endtask : dma
	// Busy may trail the request while the buffer drains, so wait on busy with a bound.
	task automatic idle;
		w = 0;
		while ((txb | rxb) !== 1'b0 && w < 60) begin
			@(posedge clk);
			w++;
		end
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask : idle
	always @(posedge clk) begin
		cyc++;
		n1 += int'(irq1);
		n2 += int'(irq2);
		tr += int'(txr && !txd);
		rr += int'(rxr && !rxd);
		ol += int'(!oe_n);
		txd = txr;
		rxd = rxr;
		if (cyc == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	initial begin
		{rstn, flyby, edge_m, dsp_wr, dsp_rd, txm, rxm, cmd, byt, dsp_addr, dsp_wdata} = '0;
		{dma_mode, hold} = 2'h3;
		bmode = BUS_SEPARATE;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk({txb, rxb, txr, rxr, irq1, irq2, oe_n, rdy}, 16'h0003);
		@(posedge clk);
		hold <= 1'b0;
		for (int m = 0; m < 8; m++) begin
			bmode <= bus_mode_e'(m[0]);
			flyby <= m[1];
			edge_m <= m[2];
			txm <= 1'($random(seed));
			rxm <= 1'($random(seed));
			n = (m == 0) ? 18 : (m == 4) ? 1 : 1 + $unsigned($random(seed)) % 18;
			e1 = n1;
			r0 = tr;
			dsp(1'b1, ADDR_TX_BULK, 16'(n));
			dsp(1'b0, ADDR_STATUS, 16'h0000);
			chk({txb, txr}, 2'h3);
			chk(r, 16'h0001);
			dsp(1'b0, ADDR_TX_BULK, 16'h0000);
			chk(r, 16'(n));
			for (k = 0; k < n; k++) begin
				if (m[2] == 1'b0 && m[0] && k == 0) begin
					hold <= 1'b1;
					dma(2'h1, 8'h5A);
					hold <= 1'b0;
					chk(txr, 1'b1);
				end
				if (m == 0 && k == 0) begin
					dsp_addr <= 5'h08;
					dsp_wdata <= 16'h0000;
					dsp_wr <= 1'b1;
				end
				if (m[2] == 1'b0 && k == n - 1) begin
					chk(txr, 1'b1);
				end
				b = 8'($random(seed));
				q.push_back(b);
				dma(2'h1, b);
				if (m == 0 && k == 1) begin
					@(negedge clk);
					chk(rdy, 1'b0);
					@(posedge clk);
					dsp_wr <= 1'b0;
				end
			end
			idle();
			chk({txr, txb}, 2'h0);
			chk(16'(n1 - e1), 16'(!txm));
			chk(16'(tr - r0), m[2] ? 16'(n) : 16'h0001);
			@(posedge clk);
			for (k = 0; k < (n + 1) / 2; k++) begin
				dsp(1'b0, ADDR_TX_BASE + 5'(k), 16'h0000);
				hi = (2 * k + 1 < n) ? q[2 * k + 1] : r[15:8];
				chk(r, {hi, q[2 * k]});
			end
			// The byte aliases of word 8 only hold bulk data when the bulk filled it.
			if (n == 18) begin
				dsp(1'b0, ADDR_TX_LO, 16'h0000);
				chk(r, {8'h00, q[16]});
				dsp(1'b0, ADDR_TX_HI, 16'h0000);
				chk(r, {8'h00, q[17]});
			end
			q.delete();
			for (k = 0; k < 9; k++) begin
				rq[k] = 16'($random(seed));
				dsp(1'b1, ADDR_RX_BASE + 5'(k), rq[k]);
			end
			// Upper data bits are set so that an alias taking them would show.
			rq[8] = ~rq[8];
			dsp(1'b1, ADDR_RX_LO, {8'hFF, rq[8][7:0]});
			dsp(1'b1, ADDR_RX_HI, {8'hFF, rq[8][15:8]});
			dsp(1'b0, ADDR_RX_BASE + 5'h08, 16'h0000);
			chk(r, rq[8]);
			e1 = n2;
			r0 = rr;
			o0 = ol;
			dsp(1'b1, ADDR_RX_BULK, 16'(n));
			chk({rxb, rxr}, 2'h3);
			for (k = 0; k < n; k++) begin
				dma(2'h2, 8'h00);
				@(negedge clk);
				chk(dout, rq[k / 2][8 * (k % 2) +: 8]);
				@(posedge clk);
			end
			idle();
			chk({rxr, rxb}, 2'h0);
			chk(16'(ol - o0), 16'(n));
			chk(16'(n2 - e1), 16'(!rxm));
			chk(16'(rr - r0), m[2] ? 16'(n) : 16'h0001);
			@(posedge clk);
		end
		dma_mode <= 1'b0;
		edge_m <= 1'b0;
		dsp(1'b1, ADDR_TX_BASE, 16'h1234);
		dsp(1'b1, ADDR_TX_BULK, 16'h0003);
		chk(txr, 1'b0);
		dma(2'h1, 8'hA5);
		dsp(1'b0, ADDR_TX_BASE, 16'h0000);
		chk(r, 16'h1234);
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
